// file: logic/iolsg_pkg.sv
// Package with the register map, reset values and bus carrier of the line select block.
package iolsg_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Byte offsets of the registers.
    localparam logic [11:0] OFF_OWNER_TAKE  = 12'h000;
    localparam logic [11:0] OFF_OWNER_GIVE  = 12'h004;
    localparam logic [11:0] OFF_OWNER_STATE = 12'h008;
    localparam logic [11:0] OFF_OUT_SET     = 12'h030;
    localparam logic [11:0] OFF_OUT_CLEAR   = 12'h034;
    localparam logic [11:0] OFF_OUT_LEVEL   = 12'h038;
    localparam logic [11:0] OFF_PIN_SAMPLE  = 12'h03C;
    localparam logic [11:0] OFF_EVT_MASK    = 12'h048;
    localparam logic [11:0] OFF_EVT_FLAGS   = 12'h04C;
    localparam logic [11:0] OFF_PULLUP      = 12'h068;
    localparam logic [11:0] OFF_FUNC_A      = 12'h070;
    localparam logic [11:0] OFF_FUNC_B      = 12'h074;
    localparam logic [11:0] OFF_FUNC_STATE  = 12'h078;
    localparam logic [11:0] OFF_WR_UNLOCK   = 12'h0A0;
    localparam logic [11:0] OFF_WR_LOCK     = 12'h0A4;
    localparam logic [11:0] OFF_WR_STATE    = 12'h0A8;

    // Reset values.
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    localparam logic [31:0] RST_PULLUP      = 32'h0000_0000;
    localparam logic [31:0] RST_FUNC_STATE  = 32'h0000_0000;
    localparam logic [31:0] RST_WR_STATE    = 32'h0000_0000;
    localparam logic [31:0] RST_EVT_FLAGS   = 32'h0000_0000;
    localparam logic [31:0] RST_EVT_MASK    = 32'h0000_0000;
    localparam logic [31:0] RST_OUT_LEVEL   = 32'h0000_0000;
    localparam logic [31:0] RST_OWNER_DFLT  = 32'hFFFF_FFFF;

    // One register bus request as issued by the master in one cycle.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } iolsg_bus_req_s;

endpackage

// file: logic/iolsg_setclr.sv
// Per-line state register driven by separate set and clear vectors.
`timescale 1ns/1ps
module iolsg_setclr
    import iolsg_pkg::*;
#(
    parameter logic [31:0] RESET_VAL = RST_ZERO
)
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [31:0] set_bits,
    input  wire logic [31:0] clr_bits,
    output logic      [31:0] state_q
);

    // Set is applied after clear, so a line named in both ends up set.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= RESET_VAL;
        end else begin
            state_q <= (state_q & ~clr_bits) | set_bits;
        end
    end

endmodule

// file: logic/iolsg_sync2.sv
// Two flip-flop synchroniser for the asynchronous line inputs.
`timescale 1ns/1ps
module iolsg_sync2
    import iolsg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic [31:0] async_in,
    output logic      [31:0] sync_out
);

    logic [31:0] stage1_q;
    logic [31:0] stage2_q;

    // The first stage is read only by the second; no reset so metastable values settle freely.
    always_ff @(posedge core_clk) begin
        stage1_q <= async_in;
        stage2_q <= stage1_q;
    end

    assign sync_out = stage2_q;

endmodule

// file: logic/iolsg_top.sv
// Line ownership, peripheral select, output write guard and pin sampling registers.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module iolsg_top
    import iolsg_pkg::*;
#(
    parameter logic [31:0] OWNER_RESET = RST_OWNER_DFLT
)
(
    input  wire logic           core_clk,
    input  wire logic           srst,
    input  wire iolsg_bus_req_s bus_req,
    output logic      [31:0]    rd_data,
    output logic                rd_valid,
    input  wire logic [31:0]    line_in,
    input  wire logic [31:0]    func_a_out,
    input  wire logic [31:0]    func_b_out,
    input  wire logic [31:0]    pullup_level_in,
    input  wire logic           ctrl_clk_en,
    output logic      [31:0]    line_out,
    output logic      [31:0]    line_owner,
    output logic      [31:0]    func_select,
    output logic                irq
);

    // Decoded write strobes, one per writable register.
    // Each is a plain decode of the request now on the bus, so a write lands
    // at the very edge that presents it and the master is never held off.
    // Reads need no strobe of their own here; they only steer the read mux.
    logic        wr_owner_take;
    logic        wr_owner_give;
    logic        wr_out_set;
    logic        wr_out_clear;
    logic        wr_out_level;
    logic        wr_evt_mask;
    logic        wr_evt_flags;
    logic        wr_func_a;
    logic        wr_func_b;
    logic        wr_unlock;
    logic        wr_lock;

    // Set and clear vectors feeding the per-line state registers.
    // The owner, function, guard and level registers are each built from one set
    // and one clear vector, so all four share the same set-wins behaviour.
    logic [31:0] owner_set;
    logic [31:0] owner_clr;
    logic [31:0] func_set;
    logic [31:0] func_clr;
    logic [31:0] guard_set;
    logic [31:0] guard_clr;
    logic [31:0] level_set;
    logic [31:0] level_clr;

    // Per-line state.
    // Bit n of every vector below belongs to I/O line n.
    logic [31:0] owner_q;
    logic [31:0] func_q;
    logic [31:0] guard_q;
    logic [31:0] level_q;
    logic [31:0] pullup_q;
    logic [31:0] sample_q;
    logic [31:0] sample_d;
    logic [31:0] evt_flags_q;
    logic [31:0] evt_flags_d;
    logic [31:0] evt_mask_q;
    logic [31:0] evt_hits;

    // Synchronised line levels.
    // Only the second synchroniser stage is visible outside the synchroniser.
    logic [31:0] line_sync;

    // Read path.
    // The read data register holds zero whenever no read is being answered.
    logic [31:0] rd_mux;
    logic [31:0] rd_data_q;
    logic        rd_valid_q;

    // Pin outputs.
    logic [31:0] line_out_q;
    logic        irq_q;

    // Write decode compares the full byte address, so misaligned or reserved
    // offsets match nothing and a write there changes no state.
    // The trade-off is that no register is aliased, so software must use the
    // exact word offset; a near miss is silently ignored.
    always_comb begin
        wr_owner_take = bus_req.wr && (bus_req.addr == OFF_OWNER_TAKE);
        wr_owner_give = bus_req.wr && (bus_req.addr == OFF_OWNER_GIVE);
        wr_out_set    = bus_req.wr && (bus_req.addr == OFF_OUT_SET);
        wr_out_clear  = bus_req.wr && (bus_req.addr == OFF_OUT_CLEAR);
        wr_out_level  = bus_req.wr && (bus_req.addr == OFF_OUT_LEVEL);
        wr_evt_mask   = bus_req.wr && (bus_req.addr == OFF_EVT_MASK);
        wr_evt_flags  = bus_req.wr && (bus_req.addr == OFF_EVT_FLAGS);
        wr_func_a     = bus_req.wr && (bus_req.addr == OFF_FUNC_A);
        wr_func_b     = bus_req.wr && (bus_req.addr == OFF_FUNC_B);
        wr_unlock     = bus_req.wr && (bus_req.addr == OFF_WR_UNLOCK);
        wr_lock       = bus_req.wr && (bus_req.addr == OFF_WR_LOCK);
    end

    // Ownership: the take register hands a line to the controller, the give
    // register hands it back to the selected peripheral; zero bits do nothing.
    // Writing the same word twice leaves the same state, so a retried write
    // does no harm.
    always_comb begin
        owner_set = wr_owner_take ? bus_req.wdata : RST_ZERO;
        owner_clr = wr_owner_give ? bus_req.wdata : RST_ZERO;
    end

    // Function select pair: A clears the status bit, B sets it.
    // A status bit of zero routes function A to the line and one routes B.
    // The selection only matters while the controller does not own the line.
    always_comb begin
        func_clr = wr_func_a ? bus_req.wdata : RST_ZERO;
        func_set = wr_func_b ? bus_req.wdata : RST_ZERO;
    end

    // Output write guard: unlock sets a line's permission, lock removes it.
    // Neither write touches the output level itself; the guard only decides
    // which lines a later direct write may change.
    always_comb begin
        guard_set = wr_unlock ? bus_req.wdata : RST_ZERO;
        guard_clr = wr_lock ? bus_req.wdata : RST_ZERO;
    end

    // Output level: the set and clear registers reach every line, while a
    // direct write is limited to lines whose guard bit is set, so software
    // that owns only some lines cannot disturb the others by accident.
    // The bus never presents two writes at once, so the three branches never
    // compete; the direct write is placed last only for readability.
    // A guarded line keeps its level bit, because both vectors stay zero there.
    always_comb begin
        level_set = RST_ZERO;
        level_clr = RST_ZERO;
        if (wr_out_set) begin
            level_set = bus_req.wdata;
        end
        if (wr_out_clear) begin
            level_clr = bus_req.wdata;
        end
        if (wr_out_level) begin
            level_set = bus_req.wdata & guard_q;
            level_clr = ~bus_req.wdata & guard_q;
        end
    end

    // Line owner state, reset value chosen per implementation.
    // A set bit means the controller drives the line rather than a peripheral.
    iolsg_setclr #(
        .RESET_VAL (OWNER_RESET)
    ) u_owner (
        .core_clk  (core_clk),
        .srst      (srst),
        .set_bits  (owner_set),
        .clr_bits  (owner_clr),
        .state_q   (owner_q)
    );

    // Function select state, zero after reset selects function A everywhere.
    // Its value is also brought out on a port for the pad multiplexer.
    iolsg_setclr #(
        .RESET_VAL (RST_FUNC_STATE)
    ) u_func (
        .core_clk  (core_clk),
        .srst      (srst),
        .set_bits  (func_set),
        .clr_bits  (func_clr),
        .state_q   (func_q)
    );

    // Output write guard state, all lines locked after reset.
    // Starting locked means a stray direct write after reset cannot move a pin.
    iolsg_setclr #(
        .RESET_VAL (RST_WR_STATE)
    ) u_guard (
        .core_clk  (core_clk),
        .srst      (srst),
        .set_bits  (guard_set),
        .clr_bits  (guard_clr),
        .state_q   (guard_q)
    );

    // Output level state driven on controller-owned lines.
    // Set and clear writes reach every line; only the direct write is guarded.
    iolsg_setclr #(
        .RESET_VAL (RST_OUT_LEVEL)
    ) u_level (
        .core_clk  (core_clk),
        .srst      (srst),
        .set_bits  (level_set),
        .clr_bits  (level_clr),
        .state_q   (level_q)
    );

    // Line levels arrive from the pads with no relation to core_clk.
    // Two stages trade two cycles of latency for a low chance of a metastable
    // value reaching the sample and the change detector.
    iolsg_sync2 u_line_sync (
        .core_clk  (core_clk),
        .async_in  (line_in),
        .sync_out  (line_sync)
    );

    // Pull-up state mirrors the pad control from the neighbouring block; it
    // is forced to zero in reset so the first read after reset is defined.
    // The pull-up control itself lives in the neighbouring register set, so
    // this copy lags it by one cycle and cannot be written from here.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pullup_q <= RST_PULLUP;
        end else begin
            pullup_q <= pullup_level_in;
        end
    end

    // The sample only moves while the controller clock is on; when it is
    // gated the last captured levels stay visible instead of going stale-X.
    // The limitation is that a line which toggles while the clock is off and
    // returns to its old level leaves no trace at all.
    always_comb begin
        sample_d = ctrl_clk_en ? line_sync : sample_q;
    end

    // Reset loads the present line levels rather than a constant, since the
    // sample has no meaningful fixed value.
    // Loading the live value also keeps the change detector from reporting a
    // false edge on every line that happens to be high when reset ends.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sample_q <= line_sync;
        end else begin
            sample_q <= sample_d;
        end
    end

    // A change is any line whose sample differs from the previous one.
    // No change can be seen while the clock is off because the sample holds.
    // Comparing against the next sample lets a flag rise at the same edge at
    // which the new level shows in the pin sample register.
    always_comb begin
        evt_hits    = sample_d ^ sample_q;
        evt_flags_d = evt_flags_q;
        if (wr_evt_flags) begin
            evt_flags_d = evt_flags_d & ~bus_req.wdata;
        end
        // New changes are merged after the clear so none is lost.
        evt_flags_d = evt_flags_d | evt_hits;
    end

    // Flags start at zero but latch changes from the first cycle after
    // reset, so an early read can already show bits set.
    // Writing one clears a flag and writing zero leaves it, so software can
    // acknowledge some lines without losing events on the others.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            evt_flags_q <= RST_EVT_FLAGS;
        end else begin
            evt_flags_q <= evt_flags_d;
        end
    end

    // Interrupt mask, one bit per line, written directly.
    // A masked flag still latches and reads back; the mask only keeps it off
    // the interrupt output.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            evt_mask_q <= RST_EVT_MASK;
        end else if (wr_evt_mask) begin
            evt_mask_q <= bus_req.wdata;
        end
    end

    // Level interrupt from the registered flags; it lags the flag by a cycle.
    // Registering the request keeps the output free of decode glitches, at the
    // cost of that single cycle of latency.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_flags_q & evt_mask_q);
        end
    end

    // Pin multiplexer: controller level on owned lines, otherwise the
    // peripheral picked by the function status bit.
    // The drive is registered, so every change of owner, level or selection
    // reaches the pin one cycle later.
    // Peripheral values pass through the mux with the same cycle of lag.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            line_out_q <= RST_ZERO;
        end else begin
            line_out_q <= (owner_q & level_q)
                        | (~owner_q & func_q & func_b_out)
                        | (~owner_q & ~func_q & func_a_out);
        end
    end

    // Read multiplexer; write-only and reserved offsets return zero.
    // Write-only registers have no storage of their own to show, so reading
    // them gives zero like any reserved offset.
    always_comb begin
        unique case (bus_req.addr)
            OFF_OWNER_STATE: rd_mux = owner_q;
            OFF_OUT_LEVEL:   rd_mux = level_q;
            OFF_PIN_SAMPLE:  rd_mux = sample_q;
            OFF_EVT_MASK:    rd_mux = evt_mask_q;
            OFF_EVT_FLAGS:   rd_mux = evt_flags_q;
            OFF_PULLUP:      rd_mux = pullup_q;
            OFF_FUNC_STATE:  rd_mux = func_q;
            OFF_WR_STATE:    rd_mux = guard_q;
            default:         rd_mux = RST_ZERO;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe and are zero
    // otherwise, which keeps a wired-OR bus fabric safe.
    // Reads have no side effect on any register, so software may poll the
    // status registers as often as it likes.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data_q  <= RST_ZERO;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= bus_req.rd ? rd_mux : RST_ZERO;
            rd_valid_q <= bus_req.rd;
        end
    end

    // All outputs come straight from flip-flops.
    // Nothing combinational reaches a port, so the pad ring and the interrupt
    // controller see clean, settled levels.
    assign rd_data     = rd_data_q;
    assign rd_valid    = rd_valid_q;
    assign line_out    = line_out_q;
    assign line_owner  = owner_q;
    assign func_select = func_q;
    assign irq         = irq_q;

endmodule

// file: verif/iolsg_monitor.sv
// Checker of the register map, function select and line drive rules at the top ports.
`timescale 1ns/1ps
module iolsg_monitor
    import iolsg_pkg::*;
#(
    parameter logic [31:0] OWNER_RESET = RST_OWNER_DFLT
)
(
    input wire logic           core_clk,
    input wire logic           srst,
    input wire iolsg_bus_req_s bus_req,
    input wire logic [31:0]    rd_data,
    input wire logic           rd_valid,
    input wire logic [31:0]    func_a_out,
    input wire logic [31:0]    func_b_out,
    input wire logic [31:0]    line_out,
    input wire logic [31:0]    line_owner,
    input wire logic [31:0]    func_select,
    input wire logic           irq
);
    // One clock domain, so reset masks every check here.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Decoded bus requests used by several checks.
    wire wr_fa = bus_req.wr && bus_req.addr == OFF_FUNC_A;
    wire wr_fb = bus_req.wr && bus_req.addr == OFF_FUNC_B;
    wire rd_wo = bus_req.rd && bus_req.addr inside {OFF_FUNC_A, OFF_FUNC_B, OFF_WR_UNLOCK,
                 OFF_WR_LOCK, 12'h07C, 12'h0AC};

    // The function select and guard write-only offsets and two reserved offsets must never leak stale data.
    wo_read_zero_a: assert property (rd_wo |=> rd_valid && rd_data == 32'h0000_0000)
        else $error("write-only or reserved offset read nonzero");
    func_b_set_a: assert property (
        wr_fb |=> (func_select & $past(bus_req.wdata)) == $past(bus_req.wdata))
        else $error("function B select did not set status");
    func_a_clr_a: assert property (
        wr_fa |=> (func_select & $past(bus_req.wdata)) == 32'h0000_0000)
        else $error("function A select did not clear status");
    func_keep_a: assert property (!(wr_fa || wr_fb) |=> $stable(func_select))
        else $error("function status changed without a select write");
    func_read_a: assert property (
        bus_req.rd && bus_req.addr == OFF_FUNC_STATE |=> rd_data == $past(func_select))
        else $error("function status read wrong");
    owner_take_a: assert property (
        bus_req.wr && bus_req.addr == OFF_OWNER_TAKE |=>
        (line_owner & $past(bus_req.wdata)) == $past(bus_req.wdata))
        else $error("owner take did not give line to controller");
    owner_read_a: assert property (
        bus_req.rd && bus_req.addr == OFF_OWNER_STATE |=> rd_data == $past(line_owner))
        else $error("owner status read wrong");
    periph_drive_a: assert property (
        !$past(srst) |-> (line_out & ~$past(line_owner)) ==
        $past(~line_owner & ((func_select & func_b_out) | (~func_select & func_a_out))))
        else $error("peripheral owned line drives wrong function");
    reset_val_a: assert property (
        $fell(srst) |-> line_owner == OWNER_RESET && func_select == 32'h0000_0000)
        else $error("owner or function status reset value wrong");

    // Main scenarios reached by the bench.
    cov_func_b: cover property (wr_fb);
    cov_irq: cover property ($rose(irq));
    cov_guard_rd: cover property (bus_req.rd && bus_req.addr == OFF_WR_STATE);
endmodule

bind iolsg_top iolsg_monitor #(.OWNER_RESET(OWNER_RESET)) u_mon (.core_clk, .srst, .bus_req,
    .rd_data, .rd_valid, .func_a_out, .func_b_out, .line_out, .line_owner, .func_select, .irq);

// file: verif/iolsg_partner.sv
// Model of the pads and the two peripheral functions beside the block.
`timescale 1ns/1ps
module iolsg_partner
#(
    parameter logic [31:0] A_PAT = 32'h3C3C_A5A5,
    parameter logic [31:0] B_PAT = 32'hC3C3_5A5A
)
(
    input  wire logic [31:0] pad_drive,
    input  wire logic [31:0] pull_en,
    output logic      [31:0] line_in,
    output logic      [31:0] func_a_out,
    output logic      [31:0] func_b_out,
    output logic      [31:0] pullup_level_in
);
    // Peripherals drive fixed, different patterns so a wrong A/B choice shows on the line.
    assign line_in         = pad_drive;
    assign func_a_out      = A_PAT;
    assign func_b_out      = B_PAT;
    assign pullup_level_in = pull_en;
endmodule

// file: verif/tb_iolsg_top.sv
// Self-checking bench of the line select and output write guard block.
`timescale 1ns/1ps
module tb_iolsg_top import iolsg_pkg::*;;
    localparam logic [31:0] A_PAT = 32'h3C3C_A5A5;
    localparam logic [31:0] B_PAT = 32'hC3C3_5A5A;
    localparam logic [31:0] MIX_EXP = (B_PAT & 32'h0000_00C0) | (A_PAT & 32'h0000_003F);
    logic           core_clk    = 1'b0;
    logic           srst        = 1'b1;
    iolsg_bus_req_s bus_req     = '0;
    logic           ctrl_clk_en = 1'b1;
    logic [31:0]    pad_drive   = 32'h0000_0000;
    logic [31:0]    pull_en     = 32'h0000_0000;
    logic [31:0]    rd_data, line_in, func_a_out, func_b_out, pullup_level_in;
    logic [31:0]    line_out, line_owner, func_select;
    logic           rd_valid, irq;
    int             errors      = 0;
    int             n_checks    = 0;

    // Free running 200 MHz clock.
    always #2.5 core_clk = ~core_clk;

    iolsg_top DUT (.core_clk, .srst, .bus_req, .rd_data, .rd_valid, .line_in, .func_a_out,
        .func_b_out, .pullup_level_in, .ctrl_clk_en, .line_out, .line_owner, .func_select, .irq);
    iolsg_partner #(.A_PAT(A_PAT), .B_PAT(B_PAT)) PM (.pad_drive, .pull_en, .line_in,
        .func_a_out, .func_b_out, .pullup_level_in);

    // Compare one word; four-state compare so an unknown never matches.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe, released at the next edge.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1 chk($sformatf("reg %h", a), exp, rd_data);
    endtask

    task automatic t_reset();
        rd(OFF_PULLUP, 32'h0000_0000);
        rd(OFF_FUNC_STATE, 32'h0000_0000);
        rd(OFF_WR_STATE, 32'h0000_0000);
        rd(OFF_OWNER_STATE, RST_OWNER_DFLT);
        rd(OFF_EVT_FLAGS, 32'h0000_0000);
        pull_en <= 32'h0000_8001;
        rd(OFF_PULLUP, 32'h0000_8001);
    endtask

    task automatic t_func();
        wr(OFF_FUNC_B, 32'h0000_00F0);
        rd(OFF_FUNC_STATE, 32'h0000_00F0);
        wr(OFF_FUNC_A, 32'h0000_0030);
        rd(OFF_FUNC_STATE, 32'h0000_00C0);
        rd(OFF_FUNC_B, 32'h0000_0000);
        wr(12'h07C, 32'hFFFF_FFFF);
        rd(12'h07C, 32'h0000_0000);
        rd(OFF_FUNC_STATE, 32'h0000_00C0);
        wr(OFF_OWNER_GIVE, 32'h0000_00FF);
        rd(OFF_OWNER_STATE, 32'hFFFF_FF00);
        chk("line_out", MIX_EXP, line_out & 32'h0000_00FF);
        wr(OFF_OWNER_TAKE, 32'h0000_000F);
        wr(OFF_OWNER_TAKE, 32'h0000_0000);
        rd(OFF_OWNER_STATE, 32'hFFFF_FF0F);
    endtask

    task automatic t_guard();
        wr(OFF_OUT_LEVEL, 32'hFFFF_FFFF);
        rd(OFF_OUT_LEVEL, 32'h0000_0000);
        wr(OFF_WR_UNLOCK, 32'h0000_00FF);
        rd(OFF_WR_STATE, 32'h0000_00FF);
        wr(OFF_OUT_LEVEL, 32'hFFFF_FFFF);
        rd(OFF_OUT_LEVEL, 32'h0000_00FF);
        wr(OFF_WR_LOCK, 32'h0000_000F);
        rd(OFF_WR_UNLOCK, 32'h0000_0000);
        wr(OFF_OUT_LEVEL, 32'h0000_0000);
        rd(OFF_OUT_LEVEL, 32'h0000_000F);
        rd(OFF_WR_STATE, 32'h0000_00F0);
        chk("line_out", 32'h0000_000F, line_out & 32'h0000_000F);
        wr(OFF_OUT_SET, 32'h0000_0F00);
        wr(OFF_OUT_CLEAR, 32'h0000_0003);
        rd(OFF_OUT_LEVEL, 32'h0000_0F0C);
        chk("line_out", 32'h0000_000C, line_out & 32'h0000_000F);
    endtask

    // Line changes pass the synchroniser in two edges and reach the sample and flags at the third; the flag raises irq one edge later.
    task automatic t_sample();
        wr(OFF_EVT_MASK, 32'h0000_0002);
        rd(OFF_EVT_MASK, 32'h0000_0002);
        pad_drive <= 32'h0000_0005;
        repeat (4) @(posedge core_clk);
        rd(OFF_PIN_SAMPLE, 32'h0000_0005);
        chk("irq", 32'h0000_0000, {31'b0, irq});
        ctrl_clk_en <= 1'b0;
        pad_drive   <= 32'h0000_000A;
        repeat (4) @(posedge core_clk);
        rd(OFF_PIN_SAMPLE, 32'h0000_0005);
        rd(OFF_EVT_FLAGS, 32'h0000_0005);
        ctrl_clk_en <= 1'b1;
        rd(OFF_PIN_SAMPLE, 32'h0000_000A);
        rd(OFF_EVT_FLAGS, 32'h0000_000F);
        chk("irq", 32'h0000_0001, {31'b0, irq});
        wr(OFF_EVT_FLAGS, 32'h0000_000F);
        rd(OFF_EVT_FLAGS, 32'h0000_0000);
        chk("irq", 32'h0000_0000, {31'b0, irq});
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence after three reset cycles.
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_func();
        t_guard();
        t_sample();
        results();
    end

    // Watchdog well beyond the roughly 100 cycles the tests need.
    initial begin
        #20000;
        errors++;
        results();
    end
endmodule
